// >>> rtl/crc_pkg.sv
package crc_pkg;

    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_FEED = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_SEED = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_RESULT = 4'hc;
    localparam logic [31:0] RST_CONTROL = 32'h2000_0000;
    localparam logic [31:0] RST_FEED = 32'h0000_0000;
    localparam logic [31:0] RST_SEED = 32'h0fff_ffff;
    localparam logic [31:0] RST_RESULT = 32'h0fff_ffff;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam int BIT_RELOAD = 1;
    localparam int BIT_ENGINE = 0;

    typedef enum logic [1:0] {POLY_CCITT, POLY_CRC8, POLY_CRC16, POLY_CRC32} poly_t;

    localparam logic [31:0] GEN_CCITT = 32'h0000_1021;
    localparam logic [31:0] GEN_CRC8 = 32'h0000_0007;
    localparam logic [31:0] GEN_CRC16 = 32'h0000_8005;
    localparam logic [31:0] GEN_CRC32 = 32'h04c1_1db7;

    // Stored control fields; the reload bit is never stored
    typedef struct packed {
        poly_t poly_select;
        logic [1:0] write_width;
        logic sum_invert;
        logic input_invert;
        logic sum_bit_flip;
        logic input_bit_flip;
        logic engine_on;
    } ctrl_t;

    function automatic logic [31:0] width_mask(input poly_t p);
        unique case (p)
            POLY_CRC8: width_mask = 32'h0000_00ff;
            POLY_CRC32: width_mask = 32'hffff_ffff;
            default: width_mask = 32'h0000_ffff;
        endcase
    endfunction

    function automatic logic [31:0] gen_of(input poly_t p);
        unique case (p)
            POLY_CCITT: gen_of = GEN_CCITT;
            POLY_CRC8: gen_of = GEN_CRC8;
            POLY_CRC16: gen_of = GEN_CRC16;
            default: gen_of = GEN_CRC32;
        endcase
    endfunction

    // One byte, most significant bit first
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b,
                                             input poly_t p);
        logic [31:0] r;
        logic [31:0] m;
        logic fb;
        r = c & width_mask(p);
        m = width_mask(p);
        for (int i = 7; i >= 0; i--)
        begin
            fb = ((r & ~(m >> 1)) != 32'h0000_0000) ^ b[i];
            r = {r[30:0], 1'b0};
            if (fb)
            begin
                r = r ^ gen_of(p);
            end
            r = r & m;
        end
        crc_byte = r;
    endfunction

    function automatic logic [31:0] rev32(input logic [31:0] v);
        for (int i = 0; i < 32; i++)
        begin
            rev32[i] = v[31-i];
        end
    endfunction

endpackage

// >>> rtl/crc_generator.sv
//Function
// - Bits 31:30 of the control register choose CCITT, CRC-8, CRC-16 or CRC-32 (00..11).
// - The four generators are the standard CCITT, CRC-8, CRC-16 and CRC-32 polynomials.
// - Bits 29:28 set the feed width: 00 low byte, 01 low halfword, 1x whole word.
// - A feed write is absorbed in one, two or four clock cycles for 8, 16 or 32 bits.
// - Control bit 27 makes the checksum read back in one's complement.
// - Control bit 26 inverts every fed data bit before it enters the calculation.
// - Control bit 25 reverses the bit order of the checksum as read back.
// - Control bit 24 reverses the bit order inside each fed byte, bytes kept in place.
// - Writing one to control bit 1 loads the seed into the checksum; the bit reads zero.
// - Calculation runs only while control bit 0 is set; writing zero to it does nothing.
// - Every write to the feed register while control bit 0 is set updates the checksum with the selected options.
// - An 8-bit result reads replicated in four bytes, a 16-bit one in both halfwords.
// - A 32-bit writable seed is used only when a reload is requested.
`timescale 1ns/1ns
`default_nettype none
module crc_generator
    import crc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    ctrl_t ctrl;
    logic [31:0] feed_word;
    logic [31:0] start_value;
    logic [31:0] running;
    logic [31:0] pending;
    logic [2:0] bytes_left;
    logic busy;
    logic wr_go;
    logic [31:0] wmerge;
    logic rd_is_sum;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++)
        begin
            merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    function automatic logic [31:0] prep(input logic [31:0] d, input ctrl_t c);
        logic [31:0] v;
        logic [31:0] w;
        v = c.input_invert ? ~d : d;
        w = v;
        if (c.input_bit_flip)
        begin
            // Bit j of a byte takes bit 7-j of the same byte
            for (int i = 0; i < 32; i++)
            begin
                v[i] = w[{i[4:3], ~i[2:0]}];
            end
        end
        prep = v;
    endfunction

    function automatic logic [31:0] sum_view(input logic [31:0] s, input ctrl_t c);
        logic [31:0] v;
        logic [31:0] m;
        m = width_mask(c.poly_select);
        v = s & m;
        if (c.sum_bit_flip)
        begin
            unique case (c.poly_select)
                POLY_CRC8: v = rev32(v) >> 24;
                POLY_CRC32: v = rev32(v);
                default: v = rev32(v) >> 16;
            endcase
        end
        if (c.sum_invert)
        begin
            v = ~v & m;
        end
        unique case (c.poly_select)
            POLY_CRC8: sum_view = {4{v[7:0]}};
            POLY_CRC32: sum_view = v;
            default: sum_view = {2{v[15:0]}};
        endcase
    endfunction

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    // Address and data are taken together, and only while the engine is idle,
    // so a feed write never lands on a half-absorbed word.
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign busy = (bytes_left != 3'd0);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready
                             && !s_axi_bvalid && !busy;
            s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready
                            && !s_axi_bvalid && !busy;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (s_axi_awaddr == OFF_CONTROL || s_axi_awaddr == OFF_FEED
                            || s_axi_awaddr == OFF_SEED) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    assign wmerge = merge({ctrl.poly_select, ctrl.write_width, ctrl.sum_invert,
                           ctrl.input_invert, ctrl.sum_bit_flip, ctrl.input_bit_flip,
                           23'h00_0000, ctrl.engine_on}, s_axi_wdata, s_axi_wstrb);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ctrl <= ctrl_t'({RST_CONTROL[31:24], RST_CONTROL[BIT_ENGINE]});
        end
        else if (wr_go && s_axi_awaddr == OFF_CONTROL)
        begin
            ctrl.poly_select <= poly_t'(wmerge[31:30]);
            ctrl.write_width <= wmerge[29:28];
            ctrl.sum_invert <= wmerge[27];
            ctrl.input_invert <= wmerge[26];
            ctrl.sum_bit_flip <= wmerge[25];
            ctrl.input_bit_flip <= wmerge[24];
            ctrl.engine_on <= ctrl.engine_on || wmerge[BIT_ENGINE];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            feed_word <= RST_FEED;
            start_value <= RST_SEED;
        end
        else if (wr_go && s_axi_awaddr == OFF_FEED)
        begin
            feed_word <= merge(feed_word, s_axi_wdata, s_axi_wstrb);
        end
        else if (wr_go && s_axi_awaddr == OFF_SEED)
        begin
            start_value <= merge(start_value, s_axi_wdata, s_axi_wstrb);
        end
    end

    // ------------------------------------------------------------
    // Engine
    // ------------------------------------------------------------
    // One byte per cycle keeps the XOR tree to a single byte step.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            running <= RST_RESULT;
            pending <= 32'h0000_0000;
            bytes_left <= 3'd0;
        end
        else if (wr_go && s_axi_awaddr == OFF_CONTROL && s_axi_wstrb[0]
                 && s_axi_wdata[BIT_RELOAD])
        begin
            running <= start_value;
        end
        else if (wr_go && s_axi_awaddr == OFF_FEED && ctrl.engine_on)
        begin
            pending <= prep(merge(feed_word, s_axi_wdata, s_axi_wstrb), ctrl);
            unique casez (ctrl.write_width)
                2'b00: bytes_left <= 3'd1;
                2'b01: bytes_left <= 3'd2;
                default: bytes_left <= 3'd4;
            endcase
        end
        else if (busy)
        begin
            running <= crc_byte(running, pending[7:0], ctrl.poly_select);
            pending <= {8'h00, pending[31:8]};
            bytes_left <= bytes_left - 3'd1;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
            rd_is_sum <= 1'b0;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                rd_is_sum <= (s_axi_araddr == OFF_RESULT);
                unique case (s_axi_araddr)
                    OFF_CONTROL: s_axi_rdata <= {ctrl.poly_select, ctrl.write_width,
                                                 ctrl.sum_invert, ctrl.input_invert,
                                                 ctrl.sum_bit_flip, ctrl.input_bit_flip,
                                                 23'h00_0000, ctrl.engine_on};
                    OFF_FEED: s_axi_rdata <= feed_word;
                    OFF_SEED: s_axi_rdata <= start_value;
                    OFF_RESULT: s_axi_rdata <= sum_view(running, ctrl);
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_seed_load:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_go && s_axi_awaddr == OFF_CONTROL && s_axi_wstrb[0] && s_axi_wdata[BIT_RELOAD]
        |=> running == $past(start_value) && !busy)
    else $error("seed not loaded into checksum");

    a_engine_sticky:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        $past(ctrl.engine_on) |-> ctrl.engine_on)
    else $error("engine enable cleared");

    a_off_no_calc:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_go && s_axi_awaddr == OFF_FEED && !ctrl.engine_on
        |=> !busy && $stable(running))
    else $error("feed absorbed while engine off");

    a_feed_byte_time:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_go && s_axi_awaddr == OFF_FEED && ctrl.engine_on && ctrl.write_width == 2'b00
        |=> busy ##1 !busy)
    else $error("8-bit feed not done in one cycle");

    a_feed_half_time:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_go && s_axi_awaddr == OFF_FEED && ctrl.engine_on && ctrl.write_width == 2'b01
        |=> busy[*2] ##1 !busy)
    else $error("16-bit feed not done in two cycles");

    a_feed_word_time:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_go && s_axi_awaddr == OFF_FEED && ctrl.engine_on && ctrl.write_width[1]
        |=> busy[*4] ##1 !busy)
    else $error("32-bit feed not done in four cycles");

    a_input_prep:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_go && s_axi_awaddr == OFF_FEED && ctrl.engine_on && s_axi_wstrb == 4'hf
        && !ctrl.input_bit_flip
        |=> pending == ($past(ctrl.input_invert) ? ~$past(s_axi_wdata) : $past(s_axi_wdata)))
    else $error("fed word not prepared as set");

    a_input_flip:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_go && s_axi_awaddr == OFF_FEED && ctrl.engine_on && s_axi_wstrb == 4'hf
        && ctrl.input_bit_flip && !ctrl.input_invert
        |=> pending[0] == $past(s_axi_wdata[7]) && pending[7] == $past(s_axi_wdata[0])
        && pending[31] == $past(s_axi_wdata[24]) && pending[9] == $past(s_axi_wdata[14]))
    else $error("fed byte bits not reversed");

    a_byte_step:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        busy |=> running == crc_byte($past(running), $past(pending[7:0]),
                                     $past(ctrl.poly_select)))
    else $error("checksum step wrong");

    a_state_kept:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        !busy && !wr_go |=> $stable(running))
    else $error("running checksum changed while idle");

    a_result_repl:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(s_axi_rvalid) && rd_is_sum && ctrl.poly_select == POLY_CRC8
        |-> s_axi_rdata == {4{s_axi_rdata[7:0]}})
    else $error("8-bit result not replicated");

endmodule // crc_generator
`default_nettype wire

// >>> verification/axi_lite_master.sv
`timescale 1ns/1ns
`default_nettype none
module axi_lite_master
    import crc_pkg::*;
(
    input wire logic clk_sys,
    output logic [ADDR_W-1:0] awaddr = '0,
    output logic awvalid = 1'b0,
    input wire logic awready,
    output logic [31:0] wdata = '0,
    output logic [3:0] wstrb = 4'h0,
    output logic wvalid = 1'b0,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready = 1'b0,
    output logic [ADDR_W-1:0] araddr = '0,
    output logic arvalid = 1'b0,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready = 1'b0
);
    // ----------------------------------------------
    // Requests
    // ----------------------------------------------
    // Leading edge wait keeps a ready low from clashing with the next raise
    task automatic do_write(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                            output logic [1:0] r, output bit ok);
        int n;
        n = 0;
        ok = 0;
        r = 2'b11;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!ok && n < 200)
        begin
            @(posedge clk_sys);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid)
            begin
                r = bresp;
                bready <= 1'b0;
                ok = 1;
            end
        end
    endtask

    task automatic do_read(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                           output logic [1:0] r, output bit ok);
        int n;
        n = 0;
        ok = 0;
        r = 2'b11;
        d = '0;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!ok && n < 200)
        begin
            @(posedge clk_sys);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                ok = 1;
            end
        end
    endtask
endmodule // axi_lite_master
`default_nettype wire

// >>> verification/tb_crc_generator.sv
`timescale 1ns/1ns
`default_nettype none
module tb_crc_generator
    import crc_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d, sd, fd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [1:0] p = 2'b00;
    logic [1:0] wl = 2'b10;
    logic sinv = 1'b0, iinv = 1'b0, srev = 1'b0, irev = 1'b0, rl;
    logic [31:0] st = RST_RESULT;
    int num_errors = 0;
    int checks = 0;

    always #5 clk_sys = ~clk_sys;

    crc_generator i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    axi_lite_master i_master (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // ----------------------------------------------
    // Reference model
    // ----------------------------------------------
    function automatic int wid();
        return (p == 2'b01) ? 8 : (p == 2'b11) ? 32 : 16;
    endfunction

    function automatic logic [31:0] msk();
        return (wid() == 32) ? 32'hffff_ffff : (32'h0000_0001 << wid()) - 32'h0000_0001;
    endfunction

    function automatic logic [31:0] gen();
        return (p == 2'b00) ? 32'h0000_1021 : (p == 2'b01) ? 32'h0000_0007 :
               (p == 2'b10) ? 32'h0000_8005 : 32'h04c1_1db7;
    endfunction

    function automatic int nbytes();
        return wl[1] ? 4 : wl[0] ? 2 : 1;
    endfunction

    // Low byte first, each byte most significant bit first
    function automatic logic [31:0] feed_ref(input logic [31:0] s, input logic [31:0] v);
        logic [7:0] b;
        int w;
        w = wid();
        if (iinv) v = ~v;
        s = s & msk();
        for (int k = 0; k < nbytes(); k++)
        begin
            b = v[8*k +: 8];
            if (irev) b = {<<{b}};
            for (int i = 7; i >= 0; i--)
                s = ((s << 1) ^ ((s[w-1] ^ b[i]) ? gen() : 32'h0000_0000)) & msk();
        end
        return s;
    endfunction

    function automatic logic [31:0] view_ref(input logic [31:0] s);
        logic [31:0] v;
        v = s & msk();
        if (srev) v = {<<{v}};
        if (srev) v = v >> (32 - wid());
        if (sinv) v = ~v & msk();
        return (wid() == 8) ? {4{v[7:0]}} : (wid() == 16) ? {2{v[15:0]}} : v;
    endfunction

    // ----------------------------------------------
    // Checks and bus access
    // ----------------------------------------------
    task automatic give_verdict();
        if (num_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) num_errors++;
        if (got !== exp) $display("Error %0t: read %h expected %h", $time, got, exp);
    endtask

    task automatic cmp_resp(input bit ok, input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (!ok || got !== exp) num_errors++;
        if (!ok || got !== exp) $display("Error %0t: response %b or timeout", $time, got);
        if (!ok) give_verdict();
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v, input logic [1:0] er);
        logic [1:0] r;
        bit ok;
        i_master.do_write(a, v, r, ok);
        cmp_resp(ok, r, er);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] er);
        logic [1:0] r;
        bit ok;
        i_master.do_read(a, d, r, ok);
        cmp_resp(ok, r, er);
    endtask

    // ----------------------------------------------
    // Main sequence
    // ----------------------------------------------
    initial
    begin
        void'($urandom(16952));
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(OFF_CONTROL, RESP_OKAY);
        cmp_val(d, 32'h2000_0000);
        rd(OFF_FEED, RESP_OKAY);
        cmp_val(d, 32'h0000_0000);
        rd(OFF_SEED, RESP_OKAY);
        cmp_val(d, 32'h0fff_ffff);
        rd(OFF_RESULT, RESP_OKAY);
        cmp_val(d, view_ref(st));
        wr(OFF_RESULT, 32'h1234_5678, RESP_SLVERR);
        rd(4'h2, RESP_SLVERR);
        cmp_val(d, 32'h0000_0000);
        // Engine still off: the word is stored but the sum must not move
        wr(OFF_FEED, 32'h5a5a_0001, RESP_OKAY);
        repeat (4) @(posedge clk_sys);
        rd(OFF_FEED, RESP_OKAY);
        cmp_val(d, 32'h5a5a_0001);
        rd(OFF_RESULT, RESP_OKAY);
        cmp_val(d, view_ref(st));
        for (int c = 0; c < 24; c++)
        begin
            p = c[1:0];
            wl = c[3:2];
            {sinv, iinv, srev, irev} = (c < 4) ? 4'h0 : 4'($urandom);
            sd = $urandom;
            rl = (c == 0) || c[2] || $urandom_range(1);
            wr(OFF_SEED, sd, RESP_OKAY);
            // Even passes after the first write zero to the enable bit
            wr(OFF_CONTROL, {p, wl, sinv, iinv, srev, irev, 22'h00_0000, rl,
                (c == 0) || c[0]}, RESP_OKAY);
            if (rl) st = sd;
            rd(OFF_CONTROL, RESP_OKAY);
            cmp_val(d, {p, wl, sinv, iinv, srev, irev, 24'h00_0001});
            for (int k = 0; k < 3; k++)
            begin
                fd = (k == 0) ? 32'haabb_ccdd : $urandom;
                wr(OFF_FEED, fd, RESP_OKAY);
                st = feed_ref(st, fd);
                repeat (nbytes()) @(posedge clk_sys);
                rd(OFF_RESULT, RESP_OKAY);
                cmp_val(d, view_ref(st));
            end
        end
        give_verdict();
    end
endmodule // tb_crc_generator
`default_nettype wire
